//--- verilog/bcs_consts.svh
// Constants for the branch and cache sequencer: widths, offsets, fields.
// Assumes inclusion by bare name from bcs_pkg.sv and the design files.
`ifndef BCS_CONSTS_SVH
`define BCS_CONSTS_SVH

`define BCS_ADDR_W 24
`define BCS_INSTR_W 48
`define BCS_SETS 16
`define BCS_IDX_W 4
`define BCS_STK_DEPTH 5'h1E
`define BCS_SP_W 5
`define BCS_PADDR_W 12
`define BCS_REG_SECONDARY_MODE_REGISTER 12'h000
`define BCS_REG_STATUS 12'h004
`define BCS_CACHE_DISABLE_BIT_BIT 4
`define BCS_CACHE_FREEZE_BIT_BIT 19
`define BCS_ST_DIS_BIT 0
`define BCS_ST_FRZ_BIT 1
`define BCS_ST_STALL_BIT 2
`define BCS_ST_SP_LSB 8
`define BCS_RESET_VECTOR 24'h000000
`define BCS_STEP_SEQ 24'h000001
`define BCS_STEP_DELAYED 24'h000003

`endif

//--- verilog/bcs_pkg.sv
// Types shared by the branch and cache sequencer files.
// Assumes bcs_consts.svh sits on the include path.
`include "bcs_consts.svh"

package bcs_pkg;

  typedef enum logic [3:0] {
    BCS_BR_JUMP = 4'b0001,
    BCS_BR_CALL = 4'b0010,
    BCS_BR_RTS = 4'b0100,
    BCS_BR_RTI = 4'b1000
  } bcs_branch_type;

  typedef enum logic [2:0] {
    BCS_TGT_ABS = 3'b001,
    BCS_TGT_REL = 3'b010,
    BCS_TGT_IND = 3'b100
  } bcs_target_type;

endpackage

//--- verilog/bcs_icache.sv
// Two-way, sixteen-set instruction cache with one LRU bit per set.
// Assumes the sequencer gates lookups and fills by the mode bits.
`timescale 1ns/100ps
`include "bcs_consts.svh"

module bcs_icache
  import bcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`BCS_ADDR_W-1:0] look_addr_i,
  input wire logic look_en_i,
  output logic hit_o,
  output logic [`BCS_INSTR_W-1:0] hit_instr_o,
  input wire logic fill_en_i,
  input wire logic [`BCS_ADDR_W-1:0] fill_addr_i,
  input wire logic [`BCS_INSTR_W-1:0] fill_instr_i
);

  logic valid_r [0:1][0:`BCS_SETS-1];
  logic [`BCS_ADDR_W-1:0] addr_r [0:1][0:`BCS_SETS-1];
  logic [`BCS_INSTR_W-1:0] instr_r [0:1][0:`BCS_SETS-1];
  logic lru_r [0:`BCS_SETS-1];

  wire [`BCS_IDX_W-1:0] look_set = look_addr_i[`BCS_IDX_W-1:0];
  wire [`BCS_IDX_W-1:0] fill_set = fill_addr_i[`BCS_IDX_W-1:0];
  wire hit0 = valid_r[0][look_set] && addr_r[0][look_set] == look_addr_i;
  wire hit1 = valid_r[1][look_set] && addr_r[1][look_set] == look_addr_i;
  wire fill_way = lru_r[fill_set];

  assign hit_o = hit0 | hit1;
  assign hit_instr_o = hit1 ? instr_r[1][look_set] : instr_r[0][look_set];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < `BCS_SETS; s++) begin
        valid_r[0][s] <= 1'b0;
        valid_r[1][s] <= 1'b0;
        lru_r[s] <= 1'b0;
      end
    end else if (fill_en_i) begin
      // Fill the entry not used last (by fill or hit), then point LRU at the other
      valid_r[fill_way][fill_set] <= 1'b1;
      addr_r[fill_way][fill_set] <= fill_addr_i;
      instr_r[fill_way][fill_set] <= fill_instr_i;
      lru_r[fill_set] <= ~fill_way;
    end else if (look_en_i && hit_o) begin
      lru_r[look_set] <= hit0;
    end
  end

  a_lru_after_fill: assert property (@(posedge clk_i)
    disable iff (rst_i) fill_en_i |=>
      lru_r[$past(fill_set)] != $past(fill_way))
    else $error("LRU still points at the filled entry");

endmodule

//--- verilog/bcs_sequencer.sv
// Fetch-side sequencer: three-stage pipeline, conflict cache, branches.
// Assumes a memory returning instr_i for fetch_addr_o in the same cycle
// and an execute stage that describes the instruction at pc_o.
//
// Function
// - Reset invalidates all cache entries; cache enabled and unfrozen.
// - Mode bit 4 set turns the cache off, clear turns it on.
// - Mode bit 19 set locks cache contents, clear allows replacement.
// - Frozen cache: a miss writes nothing and keeps LRU state.
// - Disabled cache neither supplies nor stores; every conflict stalls.
// - Freezing from instruction n still lets instruction n+2 be cached.
// - LRU per set: an entry leaves only after two other loads.
// - Call jumps and pushes next sequential address; jump pushes nothing.
// - Return fetches from top of return stack and pops it.
// - Interrupt return clears its latch bit and updates mask pointer.
// - Interrupt return pops status stack when status was pushed.
// - Direct targets absolute or PC-relative; indirect from address unit.
// - Conditional branches act only when the condition is true.
// - Immediate branch aborts the two following instructions into no-ops.
// - Immediate call pushes the decode-stage address.
// - Target fetched, then decoded, executes third cycle after branch.
// - Delayed branch loses no cycles; next two instructions execute.
// - Fetch, decode, execute pipeline at one instruction per cycle.
// - Cache: 32 pairs, 16 two-way sets by address LSBs, valid and LRU.
// - Conflict miss stalls one cycle, fetches, then fills if allowed.
// - Conflict hit supplies from cache alongside the data access.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "bcs_consts.svh"

module bcs_sequencer
  import bcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`BCS_PADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [`BCS_INSTR_W-1:0] instr_i,
  output logic [`BCS_ADDR_W-1:0] fetch_addr_o,
  output logic [`BCS_INSTR_W-1:0] ex_instr_o,
  output logic [`BCS_ADDR_W-1:0] pc_o,
  output logic ex_valid_o,
  input wire logic ex_pm_data_i,
  input wire logic ex_branch_i,
  input wire logic ex_cond_i,
  input wire logic ex_delayed_i,
  input wire bcs_branch_type ex_kind_i,
  input wire bcs_target_type ex_src_i,
  input wire logic [`BCS_ADDR_W-1:0] ex_target_i,
  input wire logic [`BCS_ADDR_W-1:0] dag_addr_i,
  input wire logic ex_status_pushed_i,
  input wire logic [4:0] ex_irq_index_i,
  output logic stall_o,
  output logic latch_clear_o,
  output logic [4:0] latch_clear_index_o,
  output logic mask_ptr_update_o,
  output logic status_pop_o
);

  function automatic logic [`BCS_ADDR_W-1:0] addr_add(
    input logic [`BCS_ADDR_W-1:0] a,
    input logic [`BCS_ADDR_W-1:0] b
  );
    addr_add = a + b;
  endfunction

  // Mode bits and their delayed effective copies
  logic cache_disable_bit_r;
  logic cache_freeze_bit_r;
  logic dis_eff_r;
  logic frz_d1_r;
  logic frz_eff_r;

  // Pipeline registers
  logic [`BCS_ADDR_W-1:0] fetch_addr_r;
  logic [`BCS_ADDR_W-1:0] dec_addr_r;
  logic [`BCS_INSTR_W-1:0] dec_instr_r;
  logic dec_valid_r;
  logic [`BCS_ADDR_W-1:0] ex_addr_r;
  logic [`BCS_INSTR_W-1:0] ex_instr_r;
  logic ex_valid_r;
  logic fill_pend_r;
  logic stall_r;

  // Return-address stack
  logic [`BCS_ADDR_W-1:0] stk_r [0:`BCS_STK_DEPTH-1];
  logic [`BCS_SP_W-1:0] sp_r;

  // Interrupt-return strobes
  logic latch_clear_r;
  logic [4:0] clear_index_r;
  logic mask_upd_r;
  logic status_pop_r;

  // Bus slave
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  logic cache_hit;
  logic [`BCS_INSTR_W-1:0] cache_instr;

  // Branch decode for the instruction in execute
  wire taken = ex_valid_r & ex_branch_i & ex_cond_i;
  wire imm = taken & ~ex_delayed_i;
  wire is_call = ex_kind_i == BCS_BR_CALL;
  wire is_rti = ex_kind_i == BCS_BR_RTI;
  wire is_ret = (ex_kind_i == BCS_BR_RTS) | is_rti;
  wire stk_full = sp_r == `BCS_STK_DEPTH;
  wire stk_empty = sp_r == '0;
  wire [`BCS_SP_W-1:0] sp_dec = sp_r - 5'h01;
  wire [`BCS_ADDR_W-1:0] tos = stk_empty ? '0 : stk_r[sp_dec];
  wire push = taken & is_call & ~stk_full;
  wire pop = taken & is_ret & ~stk_empty;
  // Immediate call returns to N+1, delayed call to N+3
  wire [`BCS_ADDR_W-1:0] push_addr = ex_delayed_i ?
    addr_add(ex_addr_r, `BCS_STEP_DELAYED) : dec_addr_r;
  wire [`BCS_ADDR_W-1:0] direct_tgt = (ex_src_i == BCS_TGT_REL) ?
    addr_add(ex_addr_r, ex_target_i) : ex_target_i;
  wire [`BCS_ADDR_W-1:0] target = is_ret ? tos :
    (ex_src_i == BCS_TGT_IND) ? dag_addr_i : direct_tgt;

  // Conflict handling; a taken branch owns the fetch slot
  wire cache_on = ~dis_eff_r;
  wire conflict = ex_valid_r & ex_pm_data_i & ~taken;
  wire use_cache = conflict & cache_on & cache_hit;
  wire stall = conflict & ~use_cache;
  wire fill_we = fill_pend_r & cache_on & ~frz_eff_r;
  wire [`BCS_INSTR_W-1:0] fetch_instr = use_cache ? cache_instr : instr_i;

  wire [`BCS_ADDR_W-1:0] fetch_addr_nxt = taken ? target :
    stall ? fetch_addr_r :
    addr_add(fetch_addr_r, `BCS_STEP_SEQ);
  wire dec_valid_nxt = taken ? ~imm : ~stall;
  wire ex_valid_nxt = ~imm & dec_valid_r;

  // Register decode
  wire apb_acc = psel_i & penable_i & ~pready_r;
  wire apb_done = psel_i & penable_i & pready_r;
  wire sel_mode = paddr_i == `BCS_REG_SECONDARY_MODE_REGISTER;
  wire sel_stat = paddr_i == `BCS_REG_STATUS;
  wire wr_mode = apb_done & pwrite_i & sel_mode;
  wire apb_err = ~(sel_mode | (sel_stat & ~pwrite_i));
  logic [31:0] mode_rd;
  logic [31:0] stat_rd;
  always_comb begin
    mode_rd = '0;
    mode_rd[`BCS_CACHE_DISABLE_BIT_BIT] = cache_disable_bit_r;
    mode_rd[`BCS_CACHE_FREEZE_BIT_BIT] = cache_freeze_bit_r;
    stat_rd = '0;
    stat_rd[`BCS_ST_DIS_BIT] = dis_eff_r;
    stat_rd[`BCS_ST_FRZ_BIT] = frz_eff_r;
    stat_rd[`BCS_ST_STALL_BIT] = stall_r;
    stat_rd[`BCS_ST_SP_LSB +: `BCS_SP_W] = sp_r;
  end
  wire [31:0] rd_mux = sel_mode ? mode_rd : sel_stat ? stat_rd : '0;

  bcs_icache u_cache (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .look_addr_i(fetch_addr_r),
    .look_en_i(conflict & cache_on),
    .hit_o(cache_hit),
    .hit_instr_o(cache_instr),
    .fill_en_i(fill_we),
    .fill_addr_i(fetch_addr_r),
    .fill_instr_i(instr_i)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cache_disable_bit_r <= 1'b0;
      cache_freeze_bit_r <= 1'b0;
    end else if (wr_mode) begin
      cache_disable_bit_r <= pwdata_i[`BCS_CACHE_DISABLE_BIT_BIT];
      cache_freeze_bit_r <= pwdata_i[`BCS_CACHE_FREEZE_BIT_BIT];
    end
  end

  // Freeze lags two cycles so the fill after n's conflict still lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_eff_r <= 1'b0;
      frz_d1_r <= 1'b0;
      frz_eff_r <= 1'b0;
    end else begin
      dis_eff_r <= cache_disable_bit_r;
      frz_d1_r <= cache_freeze_bit_r;
      frz_eff_r <= frz_d1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_addr_r <= `BCS_RESET_VECTOR;
      dec_valid_r <= 1'b0;
      ex_valid_r <= 1'b0;
      fill_pend_r <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      fetch_addr_r <= fetch_addr_nxt;
      dec_valid_r <= dec_valid_nxt;
      ex_valid_r <= ex_valid_nxt;
      fill_pend_r <= stall;
      stall_r <= stall;
    end
  end

  // Data path carries no reset; valid bits qualify it
  always_ff @(posedge clk_i) begin
    dec_addr_r <= fetch_addr_r;
    dec_instr_r <= fetch_instr;
    ex_addr_r <= dec_addr_r;
    ex_instr_r <= dec_instr_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_r <= '0;
    end else if (push) begin
      stk_r[sp_r] <= push_addr;
      sp_r <= sp_r + 5'h01;
    end else if (pop) begin
      sp_r <= sp_dec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_clear_r <= 1'b0;
      clear_index_r <= '0;
      mask_upd_r <= 1'b0;
      status_pop_r <= 1'b0;
    end else begin
      latch_clear_r <= taken & is_rti;
      clear_index_r <= ex_irq_index_i;
      mask_upd_r <= taken & is_rti;
      status_pop_r <= taken & is_rti & ex_status_pushed_i;
    end
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= apb_acc;
      pslverr_r <= apb_acc & apb_err;
      if (apb_acc) begin
        prdata_r <= pwrite_i ? '0 : rd_mux;
      end
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign fetch_addr_o = fetch_addr_r;
  assign ex_instr_o = ex_instr_r;
  assign pc_o = ex_addr_r;
  assign ex_valid_o = ex_valid_r;
  assign stall_o = stall_r;
  assign latch_clear_o = latch_clear_r;
  assign latch_clear_index_o = clear_index_r;
  assign mask_ptr_update_o = mask_upd_r;
  assign status_pop_o = status_pop_r;

  sequence s_imm_taken;
    imm;
  endsequence

  sequence s_two_bubbles;
    !ex_valid_r ##1 !ex_valid_r;
  endsequence

  a_reset_mode: assert property (@(posedge clk_i)
    $fell(rst_i) |-> !dis_eff_r && !frz_eff_r && !cache_disable_bit_r && !cache_freeze_bit_r)
    else $error("mode not clear after reset");

  a_frozen_no_fill: assert property (@(posedge clk_i)
    disable iff (rst_i) frz_eff_r |-> !fill_we)
    else $error("fill while frozen");

  a_disabled_stall: assert property (@(posedge clk_i)
    disable iff (rst_i) conflict && dis_eff_r |=> stall_r && fill_pend_r)
    else $error("disabled conflict did not stall");

  a_freeze_lag: assert property (@(posedge clk_i)
    disable iff (rst_i) $rose(cache_freeze_bit_r) |-> !frz_eff_r ##1 !frz_eff_r)
    else $error("freeze took effect too early");

  a_call_push: assert property (@(posedge clk_i)
    disable iff (rst_i) push |=> sp_r == $past(sp_r) + 5'h01
      && stk_r[$past(sp_r)] == $past(push_addr))
    else $error("call did not push");

  a_return_fetch: assert property (@(posedge clk_i)
    disable iff (rst_i) taken && is_ret |=> fetch_addr_r == $past(tos))
    else $error("return address not fetched");

  a_rti_strobes: assert property (@(posedge clk_i)
    disable iff (rst_i) taken && is_rti |=> latch_clear_o
      && mask_ptr_update_o ##1 !latch_clear_o)
    else $error("interrupt return strobes wrong");

  a_imm_abort: assert property (@(posedge clk_i)
    disable iff (rst_i) s_imm_taken |=> s_two_bubbles)
    else $error("immediate branch did not abort two");

  a_delayed_flow: assert property (@(posedge clk_i)
    disable iff (rst_i) taken && ex_delayed_i && dec_valid_r |=> ex_valid_r)
    else $error("delayed branch lost a slot");

  a_hit_no_stall: assert property (@(posedge clk_i)
    disable iff (rst_i) use_cache |=> !stall_r && dec_valid_r)
    else $error("cache hit stalled");

endmodule

//--- tb/bcs_pmem_model.sv
// Program memory model for the sequencer's fetch port, 64 words.
// Assumes the bench loads words straight into mem before each run.
`timescale 1ns/100ps

module bcs_pmem_model (
  input wire logic [23:0] addr_i,
  output logic [47:0] data_o
);
  logic [47:0] mem [0:63];

  // Same-cycle answer; never released, so no stale value to fake
  assign data_o = mem[addr_i[5:0]];
endmodule

//--- tb/tb_top.sv
// Bench for the sequencer: APB master, program memory, trace model.
// Assumes the package is compiled first; words in execute are decoded here.
`timescale 1ns/100ps

module tb_top
  import bcs_pkg::*;
;
  logic clk_i = 0;
  logic rst_i = 1;
  logic psel_i = 0;
  logic penable_i = 0;
  logic pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, ex_valid_o, stall_o, latch_clear_o;
  logic mask_ptr_update_o, status_pop_o;
  logic [4:0] latch_clear_index_o;
  logic [4:0] clr_idx;
  logic [47:0] instr_i, ex_instr_o;
  logic [23:0] fetch_addr_o, pc_o;
  logic [23:0] dag_addr_i = '0;
  int failures = 0;
  int check_count = 0;
  int stalls, clears, pops, masks;
  logic rec = 0;
  logic [31:0] trace[$];
  logic [31:0] exp_q[$];

  always #2.5 clk_i = ~clk_i;

  bcs_pmem_model bcs_pmem_model_inst (.addr_i(fetch_addr_o), .data_o(instr_i));

  // Execute-stage decode of the word now at pc_o
  bcs_sequencer bcs_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .instr_i(instr_i), .fetch_addr_o(fetch_addr_o),
    .ex_instr_o(ex_instr_o), .pc_o(pc_o), .ex_valid_o(ex_valid_o),
    .ex_pm_data_i(ex_valid_o & ex_instr_o[37]),
    .ex_branch_i(ex_valid_o & ex_instr_o[47]),
    .ex_cond_i(ex_instr_o[46]), .ex_delayed_i(ex_instr_o[45]),
    .ex_kind_i(bcs_branch_type'(ex_instr_o[44:41])),
    .ex_src_i(bcs_target_type'(ex_instr_o[40:38])),
    .ex_target_i(ex_instr_o[23:0]), .dag_addr_i(dag_addr_i),
    .ex_status_pushed_i(ex_instr_o[36]),
    .ex_irq_index_i(ex_instr_o[35:31]),
    .stall_o(stall_o), .latch_clear_o(latch_clear_o),
    .latch_clear_index_o(latch_clear_index_o),
    .mask_ptr_update_o(mask_ptr_update_o), .status_pop_o(status_pop_o)
  );

  // Trace of the execute slot; bubbles recorded as all ones
  // Falling edge: the stimulus edge work never races the sampling
  always @(negedge clk_i) begin
    if (rec) begin
      trace.push_back(ex_valid_o === 1'b1 ? {8'h0, pc_o} : 32'hFFFFFFFF);
      // Plain words hold their own address in the low bits
      if (ex_valid_o === 1'b1 && ex_instr_o[47] === 1'b0) begin
        check({26'h0, ex_instr_o[5:0]}, {26'h0, pc_o[5:0]});
      end
      stalls += (stall_o === 1'b1);
      masks += (mask_ptr_update_o === 1'b1);
      if (latch_clear_o === 1'b1) begin
        clears++;
        clr_idx = latch_clear_index_o;
        pops += (status_pop_o === 1'b1);
      end
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      failures++;
      finish_test();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic ee);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
    check({31'h0, e}, {31'h0, ee});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic ee);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    check({31'h0, e}, {31'h0, ee});
    if (!ee) check(r, x);
  endtask

  function automatic logic [47:0] br(logic c, logic d, logic [3:0] k,
      logic [2:0] s, logic p, logic [4:0] q, logic [23:0] t);
    return {1'b1, c, d, k, s, 1'b0, p, q, 7'h0, t};
  endfunction

  task automatic load();
    for (int i = 0; i < 64; i++) bcs_pmem_model_inst.mem[i] = 48'(i);
  endtask

  task automatic do_reset();
    rst_i <= 1;
    rec <= 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rec <= 1;
  endtask

  task automatic ex(input int a);
    exp_q.push_back(32'(a));
  endtask

  // Mode changes come over APB; the warm-up keeps the next conflict clear
  task automatic cache_run(input logic [31:0] m, input int n);
    int s0;
    wr(12'h000, m, 0);
    bcs_pmem_model_inst.mem[0] = br(1, 0, 4'h1, 3'h1, 0, 0, 24'd8);
    repeat (30) @(posedge clk_i);
    s0 = stalls;
    repeat (80) @(posedge clk_i);
    check(stalls - s0, n);
  endtask

  task automatic cache_reset();
    bcs_pmem_model_inst.mem[0] = br(1, 0, 4'h1, 3'h1, 0, 0, 24'd0);
    do_reset();
  endtask

  int srcs [8] = '{1, 2, 4, 1, 1, 1, 4, 1};
  int t;
  logic dl, p;
  logic [4:0] q;
  logic [2:0] s;

  initial begin
    void'($urandom(56));
    load();
    do_reset();
    rd(12'h000, 0, 0);
    rd(12'h004, 0, 0);
    wr(12'h000, 32'hFFFFFFFF, 0);
    rd(12'h000, 32'h00080010, 0);
    rd(12'h004, 32'h00000003, 0);
    wr(12'h004, 0, 1);
    wr(12'h008, 0, 1);
    rd(12'h008, 0, 1);
    // Branch table: jump abs, rel, ind, delayed, false, calls, rti
    for (int c = 0; c < 8; c++) begin
      // Far target: the return path cannot meet the return word again
      t = 16 + $urandom_range(0, 32);
      q = 5'($urandom);
      p = 1'($urandom);
      dl = (c == 3 || c == 6);
      s = 3'(srcs[c]);
      load();
      bcs_pmem_model_inst.mem[2] = br(c != 4, dl, c < 5 ? 4'h1 : 4'h2, s,
        0, 0, s == 3'h2 ? 24'(t - 2) : s == 3'h4 ? 24'(t + 5) : 24'(t));
      if (c >= 5) bcs_pmem_model_inst.mem[t + 1] =
        br(1, 0, c == 7 ? 4'h8 : 4'h4, 3'h1, p, q, 24'h0);
      dag_addr_i <= 24'(t);
      trace = {};
      exp_q = {};
      {stalls, clears, pops, masks} = '0;
      do_reset();
      repeat (22) @(posedge clk_i);
      rec <= 0;
      while (trace.size() > 0 && trace[0] === 32'hFFFFFFFF) trace.pop_front();
      for (int i = 0; i < 3; i++) ex(i);
      if (c == 4) begin
        for (int i = 3; i < 6; i++) ex(i);
      end else begin
        ex(dl ? 3 : -1);
        ex(dl ? 4 : -1);
        ex(t);
        ex(t + 1);
        if (c >= 5) begin
          ex(-1);
          ex(-1);
          ex(dl ? 5 : 3);
          ex(dl ? 6 : 4);
        end else begin
          ex(t + 2);
        end
      end
      foreach (exp_q[i]) check(trace[i], exp_q[i]);
      check(clears, c == 7);
      check(masks, c == 7);
      if (c == 7) check(clr_idx, q);
      check(pops, c == 7 && p);
    end
    // Conflict loop 8..12, data access at 9, fills the word at 11
    load();
    bcs_pmem_model_inst.mem[9] = 48'h0020_0000_0009;
    bcs_pmem_model_inst.mem[12] = br(1, 0, 4'h1, 3'h1, 0, 0, 24'd8);
    cache_reset();
    cache_run(32'h0, 0);
    cache_run(32'h00080010, 10);
    cache_run(32'h00080000, 0);
    cache_reset();
    cache_run(32'h00080000, 10);
    cache_reset();
    cache_run(32'h00000010, 10);
    finish_test();
  end

  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule
